// ### inc/alarm_manager_regs.vh
`ifndef ALARM_MANAGER_REGS_VH
`define ALARM_MANAGER_REGS_VH

// Clock and time base
`define CLK_PERIOD_NS     8
`define TICK_PERIOD_NS    1000000
`define TICK_CYCLES       (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// Lamp timing in milliseconds
`define BLINK_ON_MS       250
`define BLINK_OFF_MS      250
`define BLINK_PAUSE_MS    1500

// Alarm codes, equal to the blink count for every blinking alarm but the power-on sensor alarm
`define ALM_NONE          4'h0
`define ALM_OVERLOAD      4'h2
`define ALM_SENSOR        4'h3
`define ALM_OVERVOLT      4'h4
`define ALM_UNDERVOLT     4'h5
`define ALM_OVERSPEED     4'h6
`define ALM_OVERCURRENT   4'h7
`define ALM_DATA_CORRUPT  4'h8
`define ALM_OVERHEAT      4'h9
`define ALM_EXT_STOP      4'ha
`define ALM_START_PWRON   4'hb
`define ALM_SENSOR_PWRON  4'hc
`define ALM_CPU_FAULT     4'hf

// Blink count shown for the power-on sensor alarm
`define BLINKS_SENSOR     4'h3

// Limits: supply in 0.1 V, speed in r/min, temperature in 0.1 degC
`define OVERVOLT_DV       16'h017c
`define UNDERVOLT_DV      16'h00b4
`define OVERSPEED_RPM     16'h1450
`define OVERHEAT_DC       16'h0352

// History depth and snapshot width
`define HIST_DEPTH        4'ha
`define HIST_STATUS_W     16

// Power-on check timing in cycles
`define PWRON_CHECK_CYC   2'h2
`define PWRON_DONE_CYC    2'h3

`endif

// ### src/blink_lamp.v
`include "alarm_manager_regs.vh"

module blink_lamp #(
    parameter ON_MS    = `BLINK_ON_MS,
    parameter OFF_MS   = `BLINK_OFF_MS,
    parameter PAUSE_MS = `BLINK_PAUSE_MS
) (
    input  wire       clk,
    input  wire       rstn,
    input  wire       tick,
    input  wire       active,
    input  wire       solid,
    input  wire [3:0] blinks,
    output reg        lamp_on
);

    localparam [1:0] ST_PAUSE = 2'h0;
    localparam [1:0] ST_ON    = 2'h1;
    localparam [1:0] ST_OFF   = 2'h2;

    localparam [11:0] ON_LAST    = ON_MS[11:0] - 12'h001;
    localparam [11:0] OFF_LAST   = OFF_MS[11:0] - 12'h001;
    localparam [11:0] PAUSE_LAST = PAUSE_MS[11:0] - 12'h001;

    reg [1:0]  state_r;
    reg [11:0] ms_r;
    reg [3:0]  left_r;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_PAUSE;
            ms_r    <= 12'h000;
            left_r  <= 4'h0;
            lamp_on <= 1'b1;
        end else if (!active || solid) begin
            // Steady lamp: normal running or processor fault
            state_r <= ST_PAUSE;
            ms_r    <= 12'h000;
            left_r  <= blinks;
            lamp_on <= 1'b1;
        end else if (tick) begin
            case (state_r)
                ST_PAUSE: begin
                    lamp_on <= 1'b0;
                    if (ms_r >= PAUSE_LAST) begin
                        ms_r    <= 12'h000;
                        left_r  <= blinks;
                        lamp_on <= 1'b1;
                        state_r <= ST_ON;
                    end else begin
                        ms_r <= ms_r + 12'h001;
                    end
                end
                ST_ON: begin
                    if (ms_r >= ON_LAST) begin
                        ms_r    <= 12'h000;
                        lamp_on <= 1'b0;
                        left_r  <= left_r - 4'h1;
                        // Long dark gap after the last blink of a group
                        state_r <= (left_r <= 4'h1) ? ST_PAUSE : ST_OFF;
                    end else begin
                        ms_r <= ms_r + 12'h001;
                    end
                end
                ST_OFF: begin
                    if (ms_r >= OFF_LAST) begin
                        ms_r    <= 12'h000;
                        lamp_on <= 1'b1;
                        state_r <= ST_ON;
                    end else begin
                        ms_r <= ms_r + 12'h001;
                    end
                end
                default: begin
                    state_r <= ST_PAUSE;
                    ms_r    <= 12'h000;
                end
            endcase
        end
    end

endmodule // blink_lamp

// ### src/alarm_history.v
`include "alarm_manager_regs.vh"

module alarm_history #(
    parameter [3:0] DEPTH = `HIST_DEPTH,
    parameter       SW    = `HIST_STATUS_W
) (
    input  wire          clk,
    input  wire          nvm_rstn,
    input  wire          wr,
    input  wire [3:0]    wr_code,
    input  wire [SW-1:0] wr_status,
    input  wire [3:0]    rd_index,
    output reg  [3:0]    rd_code,
    output reg  [SW-1:0] rd_status,
    output reg  [3:0]    count
);

    reg [3:0]    code_mem [0:DEPTH-1];
    reg [SW-1:0] stat_mem [0:DEPTH-1];
    reg [3:0]    wp_r;
    reg [4:0]    sum;
    reg [3:0]    slot;
    integer      i;

    // Index 0 is the newest entry
    always @* begin
        sum  = {1'b0, wp_r} + {1'b0, DEPTH} - 5'h01 - {1'b0, rd_index};
        slot = (sum >= {1'b0, DEPTH}) ? sum[3:0] - DEPTH : sum[3:0];
    end

    // Cleared by the retention reset only, not by the power-up reset
    always @(posedge clk or negedge nvm_rstn) begin
        if (!nvm_rstn) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                code_mem[i] <= `ALM_NONE;
                stat_mem[i] <= {SW{1'b0}};
            end
            wp_r      <= 4'h0;
            count     <= 4'h0;
            rd_code   <= `ALM_NONE;
            rd_status <= {SW{1'b0}};
        end else begin
            if (wr) begin
                // Oldest slot is overwritten once full
                code_mem[wp_r] <= wr_code;
                stat_mem[wp_r] <= wr_status;
                wp_r           <= (wp_r == DEPTH - 4'h1) ? 4'h0 : wp_r + 4'h1;
                if (count != DEPTH) begin
                    count <= count + 4'h1;
                end
            end
            if (rd_index < count) begin
                rd_code   <= code_mem[slot];
                rd_status <= stat_mem[slot];
            end else begin
                rd_code   <= `ALM_NONE;
                rd_status <= {SW{1'b0}};
            end
        end
    end

endmodule // alarm_history

// ### src/motor_driver_alarm_manager.v
// Contract
// - Any alarm turns normally-open output on and normally-closed output off.
// - With the alarm outputs, stop the motor and blink the lamp red.
// - Clear a resettable alarm on the rising edge of the clear input.
// - Power-up restart and a software clear command also clear alarms.
// - Each alarm has fixed clearability; overcurrent, data corruption, overheat and processor fault need power-up.
// - Reject motor operation while any alarm is active.
// - Ignore clear requests while the operation input is on.
// - Alarm while turning removes drive and coasts, no braking.
// - Keep ten alarms with status snapshot, newest first, in retained storage.
// - When history is full, a new alarm overwrites the oldest entry.
// - History survives power removal and power cycling.
// - Overload alarm, two blinks, when overload lasts the configured time.
// - Sensor loss alarm; loss at power-up gives power-on sensor alarm, three blinks.
// - Overvoltage alarm, four blinks, above 38 V; clearable.
// - Undervoltage alarm, five blinks, below 18 V.
// - Overspeed alarm, six blinks, above 5200 r/min.
// - Overcurrent alarm, seven blinks; not clearable by the input.
// - Stored-data corruption alarm, eight blinks.
// - Main circuit overheat alarm, nine blinks, above 85 degC.
// - External stop alarm, ten blinks, on fault input off or software stop.
// - Start-prevention enabled and operation on at power-up gives eleven blinks.
// - Processor fault holds the lamp steadily lit; cleared only by power restart.
`include "alarm_manager_regs.vh"

module motor_driver_alarm_manager #(
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        nvm_rstn,
    input  wire        alarm_clear_in,
    input  wire        operation_in,
    input  wire        external_fault_in,
    input  wire        sensor_ok_in,
    input  wire        brake_req_in,
    input  wire [15:0] supply_dv,
    input  wire [15:0] speed_rpm,
    input  wire [15:0] temp_dc,
    input  wire        overload_in,
    input  wire [15:0] overload_time_ms,
    input  wire        overcurrent_in,
    input  wire        config_corrupt_in,
    input  wire        cpu_fault_in,
    input  wire        prevent_start_en,
    input  wire        sw_clear,
    input  wire        sw_ext_stop,
    input  wire [15:0] driver_status,
    input  wire [3:0]  hist_index,
    output reg         alarm_out_normally_open,
    output reg         alarm_out_normally_closed,
    output wire        power_alarm_lamp,
    output reg         power_alarm_lamp_red,
    output reg         drive_enable,
    output reg         brake_on,
    output reg  [3:0]  alarm_code,
    output wire [3:0]  hist_code,
    output wire [15:0] hist_status,
    output wire [3:0]  hist_count
);

    localparam [16:0] TICK_LAST = TICK_CYCLES[16:0] - 17'h00001;

    // Pin synchronisers: clear, operation, external fault, sensor
    reg  [3:0]  sync1_r;
    reg  [3:0]  sync2_r;
    wire        clr_s;
    wire        op_s;
    wire        ext_s;
    wire        sens_s;
    reg         clr_d_r;

    reg  [16:0] div_r;
    reg         tick_r;
    reg  [1:0]  st_cnt_r;
    reg         start_done_r;
    reg         pon_sensor_r;
    reg         pon_start_r;
    reg  [15:0] ol_ms_r;

    reg         alarm_r;
    reg         alarm_nxt;
    reg  [3:0]  code_nxt;
    reg  [3:0]  det_code;
    reg         raise;
    reg         clear_req;
    wire        pon_check;
    wire        clr_edge;
    wire        ol_det;
    reg  [3:0]  blinks;

    assign clr_s     = sync2_r[0];
    assign op_s      = sync2_r[1];
    assign ext_s     = sync2_r[2];
    assign sens_s    = sync2_r[3];
    assign clr_edge  = clr_s & ~clr_d_r;
    assign pon_check = (st_cnt_r == `PWRON_CHECK_CYC);
    assign ol_det    = overload_in & (ol_ms_r >= overload_time_ms);

    function clearable;
        input [3:0] code;
        begin
            case (code)
                `ALM_OVERCURRENT:  clearable = 1'b0;
                `ALM_DATA_CORRUPT: clearable = 1'b0;
                `ALM_OVERHEAT:     clearable = 1'b0;
                `ALM_CPU_FAULT:    clearable = 1'b0;
                default:           clearable = 1'b1;
            endcase
        end
    endfunction

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            clr_d_r <= 1'b0;
        end else begin
            sync1_r <= {sensor_ok_in, external_fault_in, operation_in, alarm_clear_in};
            sync2_r <= sync1_r;
            clr_d_r <= clr_s;
        end
    end

    // Millisecond tick
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_r  <= 17'h00000;
            tick_r <= 1'b0;
        end else if (div_r >= TICK_LAST) begin
            div_r  <= 17'h00000;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 17'h00001;
            tick_r <= 1'b0;
        end
    end

    // Power-on checks once the synchronisers hold pin levels
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_cnt_r     <= 2'h0;
            start_done_r <= 1'b0;
            pon_sensor_r <= 1'b0;
            pon_start_r  <= 1'b0;
        end else begin
            if (st_cnt_r != `PWRON_DONE_CYC) begin
                st_cnt_r <= st_cnt_r + 2'h1;
            end
            if (pon_check) begin
                start_done_r <= 1'b1;
                pon_sensor_r <= ~sens_s;
                pon_start_r  <= prevent_start_en & op_s;
            end else begin
                if (raise && code_nxt == `ALM_SENSOR_PWRON) begin
                    pon_sensor_r <= 1'b0;
                end
                if (raise && code_nxt == `ALM_START_PWRON) begin
                    pon_start_r <= 1'b0;
                end
            end
        end
    end

    // Overload duration in milliseconds
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ol_ms_r <= 16'h0000;
        end else if (!overload_in) begin
            ol_ms_r <= 16'h0000;
        end else if (tick_r && ol_ms_r != 16'hffff) begin
            ol_ms_r <= ol_ms_r + 16'h0001;
        end
    end

    // Detection, highest priority first
    always @* begin
        det_code = `ALM_NONE;
        if (cpu_fault_in) begin
            det_code = `ALM_CPU_FAULT;
        end else if (overcurrent_in) begin
            det_code = `ALM_OVERCURRENT;
        end else if (config_corrupt_in) begin
            det_code = `ALM_DATA_CORRUPT;
        end else if (pon_sensor_r) begin
            det_code = `ALM_SENSOR_PWRON;
        end else if (!sens_s) begin
            det_code = `ALM_SENSOR;
        end else if (temp_dc > `OVERHEAT_DC) begin
            det_code = `ALM_OVERHEAT;
        end else if (supply_dv > `OVERVOLT_DV) begin
            det_code = `ALM_OVERVOLT;
        end else if (supply_dv < `UNDERVOLT_DV) begin
            det_code = `ALM_UNDERVOLT;
        end else if (speed_rpm > `OVERSPEED_RPM) begin
            det_code = `ALM_OVERSPEED;
        end else if (ol_det) begin
            det_code = `ALM_OVERLOAD;
        end else if (!ext_s || sw_ext_stop) begin
            det_code = `ALM_EXT_STOP;
        end else if (pon_start_r) begin
            det_code = `ALM_START_PWRON;
        end
    end

    // Latch and clear of the active alarm
    always @* begin
        alarm_nxt = alarm_r;
        code_nxt  = alarm_code;
        raise     = 1'b0;
        clear_req = alarm_r & (clr_edge | sw_clear) & ~op_s & clearable(alarm_code);
        if (clear_req) begin
            alarm_nxt = 1'b0;
            code_nxt  = `ALM_NONE;
        end else if (!alarm_r && start_done_r && det_code != `ALM_NONE) begin
            alarm_nxt = 1'b1;
            code_nxt  = det_code;
            raise     = 1'b1;
        end
    end

    // Power-up reset is the power restart clear
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alarm_r                   <= 1'b0;
            alarm_code                <= `ALM_NONE;
            alarm_out_normally_open   <= 1'b0;
            alarm_out_normally_closed <= 1'b1;
            power_alarm_lamp_red      <= 1'b0;
            drive_enable              <= 1'b0;
            brake_on                  <= 1'b0;
        end else begin
            alarm_r                   <= alarm_nxt;
            alarm_code                <= code_nxt;
            alarm_out_normally_open   <= alarm_nxt;
            alarm_out_normally_closed <= ~alarm_nxt;
            power_alarm_lamp_red      <= alarm_nxt;
            // Operation refused while alarmed; drive removed so the motor coasts
            drive_enable              <= op_s & ~alarm_nxt & start_done_r;
            brake_on                  <= brake_req_in & ~op_s & ~alarm_nxt;
        end
    end

    always @* begin
        blinks = (alarm_code == `ALM_SENSOR_PWRON) ? `BLINKS_SENSOR : alarm_code;
    end

    blink_lamp u_lamp (
        .clk     (clk),
        .rstn    (rstn),
        .tick    (tick_r),
        .active  (alarm_r),
        .solid   (alarm_code == `ALM_CPU_FAULT),
        .blinks  (blinks),
        .lamp_on (power_alarm_lamp)
    );

    alarm_history u_hist (
        .clk       (clk),
        .nvm_rstn  (nvm_rstn),
        .wr        (raise),
        .wr_code   (code_nxt),
        .wr_status (driver_status),
        .rd_index  (hist_index),
        .rd_code   (hist_code),
        .rd_status (hist_status),
        .count     (hist_count)
    );

endmodule // motor_driver_alarm_manager

// ### bench/alarm_manager_sva.sv
module alarm_manager_sva (
    input logic       clk,
    input logic       rstn,
    input logic       nvm_rstn,
    input logic       operation_in,
    input logic       overcurrent_in,
    input logic       cpu_fault_in,
    input logic       alarm_out_normally_open,
    input logic       alarm_out_normally_closed,
    input logic       power_alarm_lamp,
    input logic       power_alarm_lamp_red,
    input logic       drive_enable,
    input logic       brake_on,
    input logic [3:0] alarm_code,
    input logic [3:0] hist_count
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn || !nvm_rstn);
    logic [2:0] up_cnt_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) up_cnt_r <= 3'h0;
        else if (up_cnt_r != 3'h7) up_cnt_r <= up_cnt_r + 3'h1;
    end
    sequence op_held;
        operation_in [*4];
    endsequence
    sequence raise_edge;
        alarm_code == 4'h0 ##1 alarm_code != 4'h0;
    endsequence
    alarm_pins_a: assert property (alarm_out_normally_open == (alarm_code != 4'h0) &&
        alarm_out_normally_closed == !alarm_out_normally_open) else $error("alarm outputs wrong");
    stop_drive_a: assert property (raise_edge |-> !drive_enable && power_alarm_lamp_red)
        else $error("motor not stopped on alarm");
    no_brake_a: assert property (alarm_code != 4'h0 |-> !brake_on && !drive_enable)
        else $error("brake or drive while alarmed");
    oc_raise_a: assert property (up_cnt_r == 3'h7 && alarm_code == 4'h0 && overcurrent_in &&
        !cpu_fault_in |=> alarm_code == 4'h7) else $error("overcurrent not raised");
    sticky_code_a: assert property (alarm_code inside {4'h7, 4'h8, 4'h9, 4'hf} |=> $stable(alarm_code))
        else $error("non-clearable alarm cleared");
    clear_gate_a: assert property (op_held ##0 alarm_code != 4'h0 |=> alarm_code != 4'h0)
        else $error("clear taken with operation on");
    cpu_lamp_a: assert property (alarm_code == 4'hf [*3] |-> power_alarm_lamp)
        else $error("processor fault lamp not steady");
    idle_lamp_a: assert property (alarm_code == 4'h0 [*3] |-> power_alarm_lamp && !power_alarm_lamp_red)
        else $error("idle lamp wrong");
    hist_count_a: assert property (raise_edge |-> hist_count ==
        (($past(hist_count) == 4'ha) ? 4'ha : $past(hist_count) + 4'h1)) else $error("history count wrong");
endmodule // alarm_manager_sva

bind motor_driver_alarm_manager alarm_manager_sva chk (
    .clk(clk), .rstn(rstn), .nvm_rstn(nvm_rstn), .operation_in(operation_in),
    .overcurrent_in(overcurrent_in), .cpu_fault_in(cpu_fault_in),
    .alarm_out_normally_open(alarm_out_normally_open), .alarm_out_normally_closed(alarm_out_normally_closed),
    .power_alarm_lamp(power_alarm_lamp), .power_alarm_lamp_red(power_alarm_lamp_red),
    .drive_enable(drive_enable), .brake_on(brake_on), .alarm_code(alarm_code), .hist_count(hist_count)
);

// ### bench/host_model.sv
module host_model (
    input  wire  clk,
    output logic alarm_clear_in    = 1'b0,
    output logic operation_in      = 1'b0,
    output logic external_fault_in = 1'b1
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic set_op(input logic v);
        @(posedge clk);
        operation_in <= v;
    endtask
    task automatic set_ext(input logic v);
        @(posedge clk);
        external_fault_in <= v;
    endtask
    // Pulse long enough for the pin synchroniser
    task automatic pulse_clear();
        @(posedge clk);
        alarm_clear_in <= 1'b1;
        repeat (4) @(posedge clk);
        alarm_clear_in <= 1'b0;
    endtask
    // Operation off before the clear edge
    task automatic clear_alarm();
        set_op(1'b0);
        repeat (4) @(posedge clk);
        pulse_clear();
    endtask
endmodule // host_model

// ### bench/motor_driver_alarm_manager_tb.sv
module motor_driver_alarm_manager_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TICK = 4;
    logic        clk = 1'b0, rstn = 1'b0, nvm_rstn = 1'b0, sensor_ok_in = 1'b1, brake_req_in = 1'b0;
    logic        overload_in = 1'b0, overcurrent_in = 1'b0, config_corrupt_in = 1'b0, cpu_fault_in = 1'b0;
    logic        prevent_start_en = 1'b0, sw_clear = 1'b0, sw_ext_stop = 1'b0, prev;
    logic [15:0] supply_dv = 16'h00f0, speed_rpm = 16'h0000, temp_dc = 16'h00c8, driver_status = 16'h0000;
    logic [15:0] overload_time_ms = 16'h0003;
    logic [3:0]  hist_index = 4'h0;
    logic [31:0] seed = 32'd28;
    wire         clr_in, op_in, ext_in, no, nc, lamp, red, drive, brake;
    wire [3:0]   alarm_code, hist_code, hist_count;
    wire [15:0]  hist_status;
    int          n_errors = 0, checked = 0;
    logic [19:0] hist_q[$];
    logic [3:0]  codes[12] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hf};

    always #4 clk = ~clk;
    host_model host (.clk(clk), .alarm_clear_in(clr_in), .operation_in(op_in), .external_fault_in(ext_in));
    motor_driver_alarm_manager #(.TICK_CYCLES(TICK)) dut (
        .clk(clk), .rstn(rstn), .nvm_rstn(nvm_rstn), .alarm_clear_in(clr_in), .operation_in(op_in),
        .external_fault_in(ext_in), .sensor_ok_in(sensor_ok_in), .brake_req_in(brake_req_in),
        .supply_dv(supply_dv), .speed_rpm(speed_rpm), .temp_dc(temp_dc), .overload_in(overload_in),
        .overload_time_ms(overload_time_ms), .overcurrent_in(overcurrent_in),
        .config_corrupt_in(config_corrupt_in), .cpu_fault_in(cpu_fault_in),
        .prevent_start_en(prevent_start_en), .sw_clear(sw_clear), .sw_ext_stop(sw_ext_stop),
        .driver_status(driver_status), .hist_index(hist_index), .alarm_out_normally_open(no),
        .alarm_out_normally_closed(nc), .power_alarm_lamp(lamp), .power_alarm_lamp_red(red),
        .drive_enable(drive), .brake_on(brake), .alarm_code(alarm_code), .hist_code(hist_code),
        .hist_status(hist_status), .hist_count(hist_count)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic restart();
        @(posedge clk);
        rstn <= 1'b0;
        step(2);
        @(posedge clk);
        rstn <= 1'b1;
    endtask
    task automatic stop_test();
        $display("Counts: %0d comparisons, %0d mismatches", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Raise or remove one alarm condition; boundary values give no alarm
    task automatic set_cond(input logic [3:0] c, input logic on);
        @(posedge clk);
        case (c)
            4'h2: overload_in <= on;
            4'h3: sensor_ok_in <= !on;
            4'h4: supply_dv <= on ? 16'h017d : 16'h017c;
            4'h5: supply_dv <= on ? 16'h00b3 : 16'h00b4;
            4'h6: speed_rpm <= on ? 16'h1451 : 16'h1450;
            4'h7: overcurrent_in <= on;
            4'h8: config_corrupt_in <= on;
            4'h9: temp_dc <= on ? 16'h0353 : 16'h0352;
            4'ha: host.set_ext(!on);
            4'hb: begin
                prevent_start_en <= on;
                if (on) begin
                    host.set_op(1'b1);
                    restart();
                end
            end
            4'hc: begin
                sensor_ok_in <= !on;
                if (on) restart();
            end
            default: cpu_fault_in <= on;
        endcase
    endtask
    task automatic wait_raise(input logic [3:0] c);
        int k;
        k = 0;
        step(1);
        while (alarm_code === 4'h0 && k < 200) begin
            step(1);
            k++;
        end
        hist_q.push_front({c, driver_status});
        if (hist_q.size() > 10) void'(hist_q.pop_back());
        chk_val("alarm_code", c, alarm_code);
        chk_val("outputs", 16'h0012, {no, nc, drive, red, brake});
    endtask
    task automatic run(input logic [3:0] c);
        int k;
        @(posedge clk);
        driver_status <= 16'(rnd());
        brake_req_in <= 1'(rnd());
        speed_rpm <= 16'(rnd() % 32'd5200);
        set_cond(c, 1'b1);
        if (c == 4'h2) begin
            step(4);
            chk_val("early_overload", 16'h0000, alarm_code);
        end
        wait_raise(c);
        if (c == 4'h4) begin
            k = 0;
            prev = 1'b1;
            repeat (4000 * TICK) begin
                step(1);
                if (lamp && !prev) k++;
                prev = lamp;
            end
            chk_val("blinks", 16'h0004, 16'(k));
        end
        set_cond(c, 1'b0);
        host.set_op(1'b1);
        step(4);
        chk_val("drive_alarmed", 16'h0000, drive);
        host.pulse_clear();
        step(4);
        chk_val("clear_op_on", c, alarm_code);
        host.clear_alarm();
        step(4);
        if (c inside {4'h7, 4'h8, 4'h9, 4'hf}) begin
            chk_val("no_clear", c, alarm_code);
            restart();
            step(6);
        end
        chk_val("cleared", 16'h0000, alarm_code);
        $display("Test alarm %h done", c);
    endtask

    initial begin
        #(8 * 60000);
        n_errors++;
        $display("ERROR watchdog expected finish seen timeout");
        stop_test();
    end
    initial begin
        step(4);
        @(posedge clk);
        rstn <= 1'b1;
        nvm_rstn <= 1'b1;
        step(6);
        chk_val("hist_empty", 16'h0000, hist_count);
        foreach (codes[i]) run(codes[i]);
        host.set_op(1'b1);
        step(6);
        chk_val("drive_free", 16'h0001, drive);
        host.set_op(1'b0);
        @(posedge clk);
        sw_ext_stop <= 1'b1;
        @(posedge clk);
        sw_ext_stop <= 1'b0;
        wait_raise(4'ha);
        step(4);
        @(posedge clk);
        sw_clear <= 1'b1;
        @(posedge clk);
        sw_clear <= 1'b0;
        step(3);
        chk_val("sw_clear", 16'h0000, alarm_code);
        chk_val("hist_count", 16'h000a, hist_count);
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            hist_index <= 4'(i);
            step(2);
            chk_val("hist_code", (i < 10) ? {12'h000, hist_q[i][19:16]} : 16'h0000, hist_code);
            chk_val("hist_status", (i < 10) ? hist_q[i][15:0] : 16'h0000, hist_status);
        end
        $display("Test history done");
        stop_test();
    end
endmodule // motor_driver_alarm_manager_tb
